// file: fmsup_params.svh
// Constants for the fault monitor supervisor: timing, fields, offsets
`ifndef FMSUP_PARAMS_SVH
`define FMSUP_PARAMS_SVH
`define FMS_CLK_MHZ        200
`define FMS_TICK_US        1000
`define FMS_TICK_CYC       (`FMS_TICK_US * `FMS_CLK_MHZ)
`define FMS_RC_SWITCH_US   500
`define FMS_RC_SWITCH_CYC  (`FMS_RC_SWITCH_US * `FMS_CLK_MHZ)
`define FMS_OSC_STOP_US    10
`define FMS_OSC_STOP_CYC   (`FMS_OSC_STOP_US * `FMS_CLK_MHZ)
`define FMS_SAI_STOP_US    100
`define FMS_SAI_STOP_CYC   (`FMS_SAI_STOP_US * `FMS_CLK_MHZ)
`define FMS_FRAME_NOM_CYC  4167
`define FMS_FAST_PCT       5
`define FMS_TO_125MS       12'd125
`define FMS_TO_500MS       12'd500
`define FMS_TO_2S          12'd2000
`define FMS_TO_4S          12'd4000
// Bit positions shared by the enable byte and the error byte
`define FMS_B_FLASH        0
`define FMS_B_WD           1
`define FMS_B_REC          2
`define FMS_B_OSC          3
`define FMS_B_BCLK         4
`define FMS_B_FCLK         5
// Configuration byte fields and reset values
`define FMS_CFG_WDSEL_LO   0
`define FMS_CFG_RECSEL_LO  2
`define FMS_CFG_WD_STBY    4
`define FMS_CFG_REC_STBY   5
`define FMS_CFG_RESET      8'h0a
`define FMS_SAFE_RESET     8'h00
`define FMS_ROUTE_RESET    2'h0
// Host register offsets on Wishbone
`define FMS_OFS_CMD        8'h00
`define FMS_OFS_RESP       8'h04
`define FMS_OFS_STAT       8'h08
`endif

// file: fmsup_pkg.sv
// Types for the fault monitor supervisor
package fmsup_pkg;
   typedef enum logic [3:0] {
      FMS_CMD_NONE    = 4'h0,
      FMS_CMD_SAFE    = 4'h1,
      FMS_CMD_ERRREAD = 4'h2,
      FMS_CMD_ERRCLR  = 4'h3,
      FMS_CMD_WDCLR   = 4'h4,
      FMS_CMD_ROUTE   = 4'h5,
      FMS_CMD_CONFIG  = 4'h6,
      FMS_CMD_UNMUTE  = 4'h7,
      FMS_CMD_CHASGN  = 4'h8
   } fmsup_cmd_t;
endpackage

// file: fmsup_if.sv
// Command link between host controller and supervisor
`timescale 1ns/1ps
interface fmsup_if;
   import fmsup_pkg::*;
   logic       cmdValid;
   fmsup_cmd_t cmdCode;
   logic [7:0] cmdData;
   logic       respValid;
   logic [7:0] respData;
   logic       cmdBusyN;
   logic [1:0] statusPin;
   modport device (input cmdValid, cmdCode, cmdData,
                   output respValid, respData, cmdBusyN, statusPin);
   modport host (output cmdValid, cmdCode, cmdData,
                 input respValid, respData, cmdBusyN, statusPin);
endinterface

// file: fmsup_device.sv
// Supervisor end: fault flags, watchdog, recovery counter, clock checks
// Operation
// RQ1: Enabled flash data error sets flag, stops channel
// RQ2: Flash range violation sets flag, stops channel
// RQ3: Started watchdog ignores later enable clear
// RQ4: Host clears watchdog; first expiry sets flag
// RQ5: Watchdog flag clears only after watchdog clear
// RQ6: Watchdog timeout 2 s, selectable four values
// RQ7: Optional second expiry returns to standby
// RQ8: Watchdog standby keeps flags and routing
// RQ9: Enabled recovery counter starts on any fault
// RQ10: Error clear stops recovery counter until fault
// RQ11: Recovery counter expiry sets recovery flag
// RQ12: Started recovery ignores later enable clear
// RQ13: Recovery timeout 2 s, selectable four values
// RQ14: Recovery standby clears enables, keeps flags, routing
// RQ15: Resonator stop sets flag, falls back RC
// RQ16: Busy pin low during RC switch
// RQ17: Cleared oscillator flag resets while still stopped
// RQ18: Disabled check: no flag, still RC fallback
// RQ19: Enabled bit clock stall sets flag
// RQ20: Enabled frame clock stall sets flag
// RQ21: Fast frame clock halts audio; flag if enabled
// RQ22: Overspeed halt needs unmute then channel assign
// RQ23: Any error routed to selected status pin
// RQ24: Flags sticky until error clear, readable
//
// The address map and the Wishbone register port were chosen for this implementation.
`timescale 1ns/1ps
`include "fmsup_params.svh"
module fmsup_device
   import fmsup_pkg::*;
#(
   parameter int TICK_CYC      = `FMS_TICK_CYC,
   parameter int RC_SWITCH_CYC = `FMS_RC_SWITCH_CYC,
   parameter int SAI_STOP_CYC  = `FMS_SAI_STOP_CYC,
   parameter int FRAME_NOM_CYC = `FMS_FRAME_NOM_CYC
)(
   // Clock, reset, enable
   input  wire logic       sys_clk,
   input  wire logic       srst,
   input  wire logic       ce,
   // Command link
   fmsup_if.device         link,
   // Flash access monitor, same clock
   input  wire logic       flashReadBad,
   input  wire logic       flashRangeBad,
   input  wire logic [1:0] flashChan,
   // Pins from outside
   input  wire logic       resonatorPin,
   input  wire logic       bitClkPin,
   input  wire logic       frameClkPin,
   // Playback control
   output logic [3:0]      chanStop,
   output logic            saiHalt,
   output logic            standbyReq,
   output logic            rcClkSel
);
   localparam int FAST_CYC = FRAME_NOM_CYC - (FRAME_NOM_CYC * `FMS_FAST_PCT) / 100;

   logic [7:0]  safe_reg, cfg_reg, err_reg, err_next, errSet, errClr;
   logic [1:0]  route_reg;
   logic [2:0]  resSync_reg, bclkSync_reg, fclkSync_reg;
   logic [31:0] tick_reg, rcCnt_reg, bclkIdle_reg, fclkIdle_reg, period_reg;
   logic [11:0] oscIdle_reg, wdMs_reg, recMs_reg;
   logic        msTick, oscStop_reg, oscStopD_reg, rcSwitching_reg;
   logic        wdRun_reg, wdOnce_reg, wdClrSeen_reg, recArmed_reg, recRun_reg;
   logic        fclkSeen_reg, unmuteSeen_reg, fastEvt, wdExp, recExp, stby;
   logic        cmdSafe, cmdClr, cmdWdClr;

   function automatic logic [11:0] timeoutMs(input logic [1:0] sel);
      unique case (sel)
         2'h0: timeoutMs = `FMS_TO_125MS;
         2'h1: timeoutMs = `FMS_TO_500MS;
         2'h2: timeoutMs = `FMS_TO_2S;
         2'h3: timeoutMs = `FMS_TO_4S;
      endcase
   endfunction

   assign cmdSafe  = link.cmdValid && link.cmdCode == FMS_CMD_SAFE;
   assign cmdClr   = link.cmdValid && link.cmdCode == FMS_CMD_ERRCLR;
   assign cmdWdClr = link.cmdValid && link.cmdCode == FMS_CMD_WDCLR;
   assign msTick   = tick_reg == 32'(TICK_CYC - 1);
   assign wdExp    = wdRun_reg && msTick
                     && wdMs_reg >= timeoutMs(cfg_reg[`FMS_CFG_WDSEL_LO +: 2]) - 12'h001;
   assign recExp   = recRun_reg && msTick
                     && recMs_reg >= timeoutMs(cfg_reg[`FMS_CFG_RECSEL_LO +: 2]) - 12'h001;
   assign fastEvt  = fclkSync_reg[1] && !fclkSync_reg[2] && fclkSeen_reg
                     && period_reg < 32'(FAST_CYC);
   // Standby entry from either counter
   assign stby     = (wdExp && wdOnce_reg && cfg_reg[`FMS_CFG_WD_STBY])
                     || (recExp && cfg_reg[`FMS_CFG_REC_STBY]);

   // Pin synchronisers; edges are taken between stages two and three
   always_ff @(posedge sys_clk)
      if (srst)
      begin
         resSync_reg  <= 3'h0;
         bclkSync_reg <= 3'h0;
         fclkSync_reg <= 3'h0;
      end
      else if (ce)
      begin
         resSync_reg  <= {resSync_reg[1:0], resonatorPin};
         bclkSync_reg <= {bclkSync_reg[1:0], bitClkPin};
         fclkSync_reg <= {fclkSync_reg[1:0], frameClkPin};
      end

   // Millisecond prescaler keeps the long timeouts in narrow counters
   always_ff @(posedge sys_clk)
      if (srst)
         tick_reg <= 32'h0;
      else if (ce)
         tick_reg <= msTick ? 32'h0 : tick_reg + 32'h1;

   // Command registers
   always_ff @(posedge sys_clk)
      if (srst)
      begin
         safe_reg  <= `FMS_SAFE_RESET;
         cfg_reg   <= `FMS_CFG_RESET;
         route_reg <= `FMS_ROUTE_RESET;
      end
      else if (ce)
      begin
         if (stby)
            safe_reg <= `FMS_SAFE_RESET;                           // see RQ14
         else if (cmdSafe)
            safe_reg <= link.cmdData;
         if (link.cmdValid && link.cmdCode == FMS_CMD_CONFIG)
            cfg_reg <= link.cmdData;
         if (link.cmdValid && link.cmdCode == FMS_CMD_ROUTE)
            route_reg <= link.cmdData[1:0];                        // see RQ8
      end

   // Resonator stop detection and RC fallback
   always_ff @(posedge sys_clk)
      if (srst)
      begin
         oscIdle_reg     <= 12'h0;
         oscStop_reg     <= 1'b0;
         oscStopD_reg    <= 1'b0;
         rcSwitching_reg <= 1'b0;
         rcCnt_reg       <= 32'h0;
         rcClkSel        <= 1'b0;
      end
      else if (ce)
      begin
         if (resSync_reg[2] != resSync_reg[1])
            oscIdle_reg <= 12'h0;
         else if (oscIdle_reg != 12'(`FMS_OSC_STOP_CYC))
            oscIdle_reg <= oscIdle_reg + 12'h1;
         oscStop_reg  <= oscIdle_reg == 12'(`FMS_OSC_STOP_CYC);
         oscStopD_reg <= oscStop_reg;
         // Fallback runs whatever the enable says
         if (oscStop_reg && !oscStopD_reg && !rcClkSel)
            rcSwitching_reg <= 1'b1;                               // see RQ18
         else if (rcSwitching_reg && rcCnt_reg == 32'(RC_SWITCH_CYC - 1))
         begin
            rcSwitching_reg <= 1'b0;
            rcClkSel        <= 1'b1;                               // see RQ15
         end
         rcCnt_reg <= rcSwitching_reg ? rcCnt_reg + 32'h1 : 32'h0;
      end

   // Stall timers and frame period
   always_ff @(posedge sys_clk)
      if (srst)
      begin
         bclkIdle_reg <= 32'h0;
         fclkIdle_reg <= 32'h0;
         period_reg   <= 32'h0;
         fclkSeen_reg <= 1'b0;
      end
      else if (ce)
      begin
         bclkIdle_reg <= (bclkSync_reg[2] != bclkSync_reg[1]) ? 32'h0
                         : bclkIdle_reg + {31'h0, bclkIdle_reg != 32'(SAI_STOP_CYC)};
         fclkIdle_reg <= (fclkSync_reg[2] != fclkSync_reg[1]) ? 32'h0
                         : fclkIdle_reg + {31'h0, fclkIdle_reg != 32'(SAI_STOP_CYC)};
         if (fclkSync_reg[1] && !fclkSync_reg[2])
         begin
            period_reg   <= 32'h1;
            fclkSeen_reg <= 1'b1;
         end
         else if (period_reg != 32'hffffffff)
            period_reg <= period_reg + 32'h1;
         // A stalled frame clock must not later look like a fast first period
         if (fclkIdle_reg == 32'(SAI_STOP_CYC))
            fclkSeen_reg <= 1'b0;
      end

   // Error set and clear terms
   always_comb
   begin
      errSet = 8'h0;
      errSet[`FMS_B_FLASH] = (flashReadBad && safe_reg[`FMS_B_FLASH])   // see RQ1
                             || flashRangeBad;                          // see RQ2
      errSet[`FMS_B_WD]    = wdExp && !wdOnce_reg;                       // see RQ4
      errSet[`FMS_B_REC]   = recExp;                                    // see RQ11
      errSet[`FMS_B_OSC]   = oscStop_reg && safe_reg[`FMS_B_OSC];       // see RQ17
      errSet[`FMS_B_BCLK]  = safe_reg[`FMS_B_BCLK]
                             && bclkIdle_reg == 32'(SAI_STOP_CYC);      // see RQ19
      errSet[`FMS_B_FCLK]  = safe_reg[`FMS_B_FCLK]
                             && (fclkIdle_reg == 32'(SAI_STOP_CYC)      // see RQ20
                                 || fastEvt);                           // see RQ21
      errClr = cmdClr ? 8'hff : 8'h00;
      errClr[`FMS_B_WD] = cmdClr && wdClrSeen_reg;                      // see RQ5
      err_next = (err_reg & ~errClr) | errSet;                          // see RQ24
   end

   // Sticky flags survive standby; only the reset pin or error clear drops them
   always_ff @(posedge sys_clk)
      if (srst)
         err_reg <= 8'h0;
      else if (ce)
         err_reg <= err_next;                                          // see RQ8

   // Host link watchdog
   always_ff @(posedge sys_clk)
      if (srst)
      begin
         wdRun_reg     <= 1'b0;
         wdOnce_reg    <= 1'b0;
         wdMs_reg      <= 12'h0;
         wdClrSeen_reg <= 1'b0;
      end
      else if (ce)
      begin
         if (cmdWdClr)
            wdClrSeen_reg <= 1'b1;
         else if (cmdClr)
            wdClrSeen_reg <= 1'b0;
         if (stby)
            wdRun_reg <= 1'b0;
         else if (cmdSafe && link.cmdData[`FMS_B_WD])
            wdRun_reg <= 1'b1;                                     // see RQ3
         if (cmdWdClr || stby || !wdRun_reg)
         begin
            wdMs_reg   <= 12'h0;
            wdOnce_reg <= 1'b0;
         end
         else if (wdExp)
         begin
            wdMs_reg   <= 12'h0;                                   // see RQ6
            wdOnce_reg <= 1'b1;                                    // see RQ7
         end
         else if (msTick)
            wdMs_reg <= wdMs_reg + 12'h1;
      end

   // Recovery counter
   always_ff @(posedge sys_clk)
      if (srst)
      begin
         recArmed_reg <= 1'b0;
         recRun_reg   <= 1'b0;
         recMs_reg    <= 12'h0;
      end
      else if (ce)
      begin
         if (stby)
            recArmed_reg <= 1'b0;                                  // see RQ14
         else if (cmdSafe && link.cmdData[`FMS_B_REC])
            recArmed_reg <= 1'b1;                                  // see RQ12
         if (stby || recExp)
            recRun_reg <= 1'b0;
         else if (recArmed_reg && ((|(errSet & ~(8'h1 << `FMS_B_REC))) || fastEvt))
            recRun_reg <= 1'b1;                                    // see RQ9
         else if (cmdClr)
            recRun_reg <= 1'b0;                                    // see RQ10
         if (!recRun_reg || cmdClr || recExp)
            recMs_reg <= 12'h0;                                    // see RQ13
         else if (msTick)
            recMs_reg <= recMs_reg + 12'h1;
      end

   // Playback control and the audio link halt
   always_ff @(posedge sys_clk)
      if (srst)
      begin
         chanStop       <= 4'h0;
         saiHalt        <= 1'b0;
         unmuteSeen_reg <= 1'b0;
         standbyReq     <= 1'b0;
      end
      else if (ce)
      begin
         chanStop   <= fastEvt ? 4'hf
                       : (flashRangeBad || (flashReadBad && safe_reg[`FMS_B_FLASH]))
                         ? 4'h1 << flashChan : 4'h0;               // see RQ1
         standbyReq <= stby;                                       // see RQ7
         if (fastEvt)
         begin
            saiHalt        <= 1'b1;                                // see RQ21
            unmuteSeen_reg <= 1'b0;
         end
         else if (link.cmdValid && link.cmdCode == FMS_CMD_UNMUTE)
            unmuteSeen_reg <= 1'b1;
         else if (link.cmdValid && link.cmdCode == FMS_CMD_CHASGN && unmuteSeen_reg)
         begin
            saiHalt        <= 1'b0;                                // see RQ22
            unmuteSeen_reg <= 1'b0;
         end
      end

   // Link answers and status pins
   always_ff @(posedge sys_clk)
      if (srst)
      begin
         link.respValid <= 1'b0;
         link.respData  <= 8'h0;
         link.cmdBusyN  <= 1'b1;
         link.statusPin <= 2'h0;
      end
      else if (ce)
      begin
         link.respValid <= link.cmdValid && link.cmdCode == FMS_CMD_ERRREAD;
         if (link.cmdValid && link.cmdCode == FMS_CMD_ERRREAD)
            link.respData <= err_reg;                              // see RQ24
         link.cmdBusyN  <= !rcSwitching_reg;                       // see RQ16
         link.statusPin <= (|err_reg) ? route_reg : 2'h0;          // see RQ23
      end
endmodule

// file: fmsup_host.sv
// Host end: Wishbone registers that issue link commands and hold answers
`timescale 1ns/1ps
`include "fmsup_params.svh"
module fmsup_host
   import fmsup_pkg::*;
(
   // Clock, reset, enable
   input  wire logic        sys_clk,
   input  wire logic        srst,
   input  wire logic        ce,
   // Command link
   fmsup_if.host            link,
   // Wishbone classic slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic [31:0]      wb_dat_o,
   output logic             wb_ack_o
);
   logic       pending_reg, respNew_reg, req, rdResp;
   fmsup_cmd_t code_reg;
   logic [7:0] data_reg, resp_reg;

   assign req    = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign rdResp = req && !wb_we_i && wb_adr_i == `FMS_OFS_RESP;

   // One wait state; ack drops the cycle after it is given
   always_ff @(posedge sys_clk)
      if (srst)
      begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0;
      end
      else if (ce)
      begin
         wb_ack_o <= req;
         wb_dat_o <= 32'h0;
         if (req && !wb_we_i)
            unique case (wb_adr_i)
               `FMS_OFS_CMD:  wb_dat_o <= {16'h0, data_reg, 4'h0, code_reg};
               `FMS_OFS_RESP: wb_dat_o <= {24'h0, resp_reg};
               `FMS_OFS_STAT: wb_dat_o <= {26'h0, link.statusPin, 1'b0,
                                           link.cmdBusyN, respNew_reg, pending_reg};
               default:       wb_dat_o <= 32'h0;
            endcase
      end

   // A write while a command is still pending is dropped
   always_ff @(posedge sys_clk)
      if (srst)
      begin
         pending_reg  <= 1'b0;
         code_reg     <= FMS_CMD_NONE;
         data_reg     <= 8'h0;
         link.cmdValid <= 1'b0;
         link.cmdCode  <= FMS_CMD_NONE;
         link.cmdData  <= 8'h0;
      end
      else if (ce)
      begin
         link.cmdValid <= 1'b0;
         if (req && wb_we_i && wb_adr_i == `FMS_OFS_CMD && wb_sel_i[0] && !pending_reg)
         begin
            pending_reg <= 1'b1;
            code_reg    <= fmsup_cmd_t'(wb_dat_i[3:0]);
            if (wb_sel_i[1])
               data_reg <= wb_dat_i[15:8];
         end
         else if (pending_reg && link.cmdBusyN)
         begin
            // Software keeps the order of clears and restarts; this only paces them
            pending_reg   <= 1'b0;                                 // see RQ16
            link.cmdValid <= 1'b1;                                 // see RQ5
            link.cmdCode  <= code_reg;                             // see RQ4
            link.cmdData  <= data_reg;                             // see RQ22
         end
      end

   // Answer capture; a new answer wins over the read that clears the flag
   always_ff @(posedge sys_clk)
      if (srst)
      begin
         resp_reg    <= 8'h0;
         respNew_reg <= 1'b0;
      end
      else if (ce)
      begin
         if (link.respValid)
            resp_reg <= link.respData;
         respNew_reg <= link.respValid || (respNew_reg && !rdResp);
      end
endmodule

// file: fmsup_link_sva.sv
// Link checker: answer timing, busy window and status routing
`timescale 1ns/1ps
module fmsup_link_sva
   import fmsup_pkg::*;
#(
   parameter int RC_SWITCH_CYC = 50
)(
   // Clock and reset
   input wire logic       sys_clk,
   input wire logic       srst,
   // Link
   input wire logic       cmdValid,
   input wire fmsup_cmd_t cmdCode,
   input wire logic [7:0] cmdData,
   input wire logic       respValid,
   input wire logic [7:0] respData,
   input wire logic       cmdBusyN,
   input wire logic [1:0] statusPin
);
   logic [1:0] routeReg;
   int         busyLen;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (srst);
   always_ff @(posedge sys_clk)
      if (srst)
         routeReg <= 2'h0;
      else if (cmdValid && cmdCode == FMS_CMD_ROUTE)
         routeReg <= cmdData[1:0];
   always_ff @(posedge sys_clk)
      if (srst || cmdBusyN)
         busyLen <= 0;
      else
         busyLen <= busyLen + 1;
   property p_read_answer;
      cmdValid && cmdCode == FMS_CMD_ERRREAD |=> respValid;
   endproperty
   a_read_answer: assert property (p_read_answer) else $error("read unanswered");
   property p_resp_cause;
      respValid |-> $past(cmdValid) && $past(cmdCode) == FMS_CMD_ERRREAD;
   endproperty
   a_resp_cause: assert property (p_resp_cause) else $error("answer without read");
   property p_resp_pulse;
      respValid |=> !respValid;
   endproperty
   a_resp_pulse: assert property (p_resp_pulse) else $error("answer too long");
   property p_resp_hold;
      !respValid |-> $stable(respData);
   endproperty
   a_resp_hold: assert property (p_resp_hold) else $error("answer data moved");
   property p_route_pin;
      respValid && respData != 8'h00 && routeReg != 2'h0 |-> statusPin == routeReg;
   endproperty
   a_route_pin: assert property (p_route_pin) else $error("status pin not routed");
   property p_cmd_ready;
      cmdValid |-> $past(cmdBusyN);
   endproperty
   a_cmd_ready: assert property (p_cmd_ready) else $error("command while busy");
   property p_busy_min;
      $fell(cmdBusyN) |=> !cmdBusyN [*8];
   endproperty
   a_busy_min: assert property (p_busy_min) else $error("busy too short");
   property p_busy_max;
      !cmdBusyN |-> busyLen <= RC_SWITCH_CYC + 2;
   endproperty
   a_busy_max: assert property (p_busy_max) else $error("busy too long");
   c_read: cover property (cmdValid && cmdCode == FMS_CMD_ERRREAD);
   c_busy: cover property ($fell(cmdBusyN));
   c_route: cover property (statusPin == 2'h2);
endmodule

// file: test_fault_monitor_supervisor.sv
// Testbench: host and supervisor joined over the command link
`timescale 1ns/1ps
`include "fmsup_params.svh"
module test_fault_monitor_supervisor
   import fmsup_pkg::*;
;
   // Short tick keeps the 125 ms timeout at a few thousand cycles
   localparam int TICK = 20;
   localparam int RCSW = 50;
   localparam int TO0  = int'(`FMS_TO_125MS) * TICK;
   typedef struct {
      logic       rng;
      logic [1:0] chan;
      logic [7:0] en;
      logic [7:0] err;
      logic [3:0] stop;
   } fmsup_row_t;
   fmsup_row_t  rows [3] = '{'{1'h0, 2'h2, 8'h01, 8'h01, 4'h4},
                            '{1'h0, 2'h1, 8'h00, 8'h00, 4'h0},
                            '{1'h1, 2'h3, 8'h00, 8'h01, 4'h8}};
   logic        sys_clk = 1'h0;
   logic        srst = 1'h1;
   logic        wbCyc = 1'h0, wbStb = 1'h0, wbWe = 1'h0;
   logic [7:0]  wbAdr = 8'h00;
   logic [31:0] wbDatW = 32'h0;
   logic [31:0] wbDatR;
   logic        wbAck;
   logic        flashReadBad = 1'h0, flashRangeBad = 1'h0;
   logic [1:0]  flashChan = 2'h0;
   logic        resonatorPin = 1'h0, bitClkPin = 1'h0, frameClkPin = 1'h0;
   logic [3:0]  chanStop;
   logic        saiHalt, standbyReq, rcClkSel;
   logic        oscRun = 1'h1, bclkRun = 1'h1, fclkRun = 1'h1;
   int          fHalf = 60;
   int          pinCnt = 0, standbyCnt = 0;
   int          n_mismatch = 0, cmp_count = 0;
   always #2.5 sys_clk = ~sys_clk;
   fmsup_if fmsup_if_inst ();
   fmsup_device #(.TICK_CYC(TICK), .RC_SWITCH_CYC(RCSW), .SAI_STOP_CYC(100),
      .FRAME_NOM_CYC(120)) fmsup_device_inst (.sys_clk, .srst, .ce(1'h1),
      .link(fmsup_if_inst), .flashReadBad, .flashRangeBad, .flashChan, .resonatorPin,
      .bitClkPin, .frameClkPin, .chanStop, .saiHalt, .standbyReq, .rcClkSel);
   fmsup_host fmsup_host_inst (.sys_clk, .srst, .ce(1'h1), .link(fmsup_if_inst),
      .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(4'hf),
      .wb_dat_i(wbDatW), .wb_dat_o(wbDatR), .wb_ack_o(wbAck));
   fmsup_link_sva #(.RC_SWITCH_CYC(RCSW)) fmsup_link_sva_inst (.sys_clk, .srst,
      .cmdValid(fmsup_if_inst.cmdValid), .cmdCode(fmsup_if_inst.cmdCode),
      .cmdData(fmsup_if_inst.cmdData), .respValid(fmsup_if_inst.respValid),
      .respData(fmsup_if_inst.respData), .cmdBusyN(fmsup_if_inst.cmdBusyN),
      .statusPin(fmsup_if_inst.statusPin));
   always @(posedge sys_clk)
   begin
      pinCnt <= pinCnt + 1;
      if (oscRun)
         resonatorPin <= ~resonatorPin;
      if (bclkRun && pinCnt % 4 == 0)
         bitClkPin <= ~bitClkPin;
      if (fclkRun && pinCnt % fHalf == 0)
         frameClkPin <= ~frameClkPin;
      if (standbyReq === 1'h1)
         standbyCnt <= standbyCnt + 1;
   end
   task automatic wrap_up;
      $display("cmp %0d err %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic hang(input string nm);
      n_mismatch++;
      $display("[ERR] %s expected done seen timeout", nm);
      wrap_up;
   endtask
   task automatic waitc(input int n);
      repeat (n) @(posedge sys_clk);
   endtask
   // One classic cycle; request held until ack is sampled high
   task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] d,
                     output logic [31:0] rd);
      int n;
      wbCyc <= 1'h1;
      wbStb <= 1'h1;
      wbWe <= we;
      wbAdr <= adr;
      wbDatW <= d;
      @(posedge sys_clk);
      for (n = 0; n < 20 && wbAck !== 1'h1; n++)
         @(posedge sys_clk);
      rd = wbDatR;
      if (n >= 20)
         hang("ack");
      wbCyc <= 1'h0;
      wbStb <= 1'h0;
      @(posedge sys_clk);
   endtask
   task automatic pollStat(input int b, input logic want);
      logic [31:0] r;
      int          n;
      wb(1'h0, `FMS_OFS_STAT, 32'h0, r);
      for (n = 0; n < 100 && r[b] !== want; n++)
         wb(1'h0, `FMS_OFS_STAT, 32'h0, r);
      if (n >= 100)
         hang("status");
   endtask
   task automatic cmd(input fmsup_cmd_t code, input logic [7:0] d);
      logic [31:0] r;
      pollStat(0, 1'h0);
      wb(1'h1, `FMS_OFS_CMD, {16'h0, d, 4'h0, code}, r);
   endtask
   task automatic expErr(input logic [7:0] exp);
      logic [31:0] r;
      cmd(FMS_CMD_ERRREAD, 8'h00);
      pollStat(1, 1'h1);
      wb(1'h0, `FMS_OFS_RESP, 32'h0, r);
      chk("errByte", exp, r[7:0]);
   endtask
   task automatic fault(input logic rng, input logic [1:0] ch, input logic [3:0] stp);
      flashReadBad <= !rng;
      flashRangeBad <= rng;
      flashChan <= ch;
      @(posedge sys_clk);
      flashReadBad <= 1'h0;
      flashRangeBad <= 1'h0;
      #1 chk("chanStop", stp, chanStop);
      @(posedge sys_clk);
   endtask
   initial
   begin
      logic [31:0] r;
      repeat (2) @(posedge sys_clk);
      srst <= 1'h0;
      wb(1'h0, `FMS_OFS_STAT, 32'h0, r);
      chk("stat", 32'h4, r);
      wb(1'h1, 8'h0c, 32'hff, r);
      wb(1'h0, 8'h0c, 32'h0, r);
      chk("unmapped", 32'h0, r);
      cmd(FMS_CMD_ROUTE, 8'h02);
      foreach (rows[i])
      begin
         cmd(FMS_CMD_SAFE, rows[i].en);
         fault(rows[i].rng, rows[i].chan, rows[i].stop);
         expErr(rows[i].err);
         cmd(FMS_CMD_ERRCLR, 8'h00);
         expErr(8'h00);
      end
      // Unfed watchdog with its enable dropped at once
      cmd(FMS_CMD_CONFIG, 8'h10);
      cmd(FMS_CMD_SAFE, 8'h02);
      cmd(FMS_CMD_SAFE, 8'h00);
      waitc(TO0 - 200);
      expErr(8'h00);
      waitc(300);
      expErr(8'h02);
      cmd(FMS_CMD_ERRCLR, 8'h00);
      expErr(8'h02);
      waitc(TO0);
      chk("standby", 1, standbyCnt);
      expErr(8'h02);
      wb(1'h0, `FMS_OFS_STAT, 32'h0, r);
      chk("pin", 2'h2, r[5:4]);
      cmd(FMS_CMD_WDCLR, 8'h00);
      cmd(FMS_CMD_ERRCLR, 8'h00);
      expErr(8'h00);
      // Recovery stopped by a clear, then run out after its enable is gone
      cmd(FMS_CMD_CONFIG, 8'h20);
      cmd(FMS_CMD_SAFE, 8'h05);
      fault(1'h1, 2'h0, 4'h1);
      waitc(TO0 / 2);
      cmd(FMS_CMD_ERRCLR, 8'h00);
      waitc(TO0 + 200);
      expErr(8'h00);
      fault(1'h1, 2'h0, 4'h1);
      cmd(FMS_CMD_SAFE, 8'h01);
      waitc(TO0 + 200);
      expErr(8'h05);
      chk("standby", 2, standbyCnt);
      cmd(FMS_CMD_ERRCLR, 8'h00);
      fault(1'h0, 2'h0, 4'h0);
      expErr(8'h00);
      // Resonator stop; the first read lands inside the busy window
      cmd(FMS_CMD_SAFE, 8'h00);
      oscRun <= 1'h0;
      waitc(`FMS_OSC_STOP_CYC + 10);
      expErr(8'h00);
      chk("rcSel", 1'h1, rcClkSel);
      cmd(FMS_CMD_SAFE, 8'h08);
      expErr(8'h08);
      cmd(FMS_CMD_ERRCLR, 8'h00);
      expErr(8'h08);
      oscRun <= 1'h1;
      cmd(FMS_CMD_SAFE, 8'h30);
      cmd(FMS_CMD_ERRCLR, 8'h00);
      waitc(300);
      expErr(8'h00);
      bclkRun <= 1'h0;
      waitc(300);
      expErr(8'h10);
      fclkRun <= 1'h0;
      waitc(300);
      expErr(8'h30);
      bclkRun <= 1'h1;
      fclkRun <= 1'h1;
      for (int en = 0; en < 2; en++)
      begin
         cmd(FMS_CMD_SAFE, en ? 8'h20 : 8'h00);
         cmd(FMS_CMD_ERRCLR, 8'h00);
         fHalf <= 55;
         waitc(600);
         fHalf <= 60;
         chk("halt", 1'h1, saiHalt);
         expErr(en ? 8'h20 : 8'h00);
         waitc(600);
         cmd(FMS_CMD_CHASGN, 8'h03);
         waitc(3);
         chk("halt", 1'h1, saiHalt);
         cmd(FMS_CMD_UNMUTE, 8'h00);
         cmd(FMS_CMD_CHASGN, 8'h03);
         waitc(3);
         chk("halt", 1'h0, saiHalt);
      end
      srst <= 1'h1;
      waitc(2);
      srst <= 1'h0;
      wb(1'h0, `FMS_OFS_STAT, 32'h0, r);
      chk("stat", 32'h4, r);
      chk("rcSel", 1'h0, rcClkSel);
      wrap_up;
   end
endmodule
